/* File: hw/can_flags_pkg.sv */
/*
  Constants shared by the CAN status-flag device end, its register-side
  controller, the checker and the bench.
  Assumes a single 100 MHz core clock and 32-bit APB software access.
*/
package can_flags_pkg;
  // receiver flag and enable bit positions
  localparam int WAKE_BIT = 7;
  localparam int RX_WARN_BIT = 6;
  localparam int TX_WARN_BIT = 5;
  localparam int RX_PASSIVE_BIT = 4;
  localparam int TX_PASSIVE_BIT = 3;
  localparam int BUS_OFF_BIT = 2;
  localparam int OVERRUN_BIT = 1;
  localparam int RX_FULL_BIT = 0;
  // error-class flags feeding the shared error interrupt
  localparam logic [7:0] ERROR_CLASS_MASK = 8'h7E;

  // transmitter flag layout: acknowledges high, empty flags low
  localparam int TX_BUFFERS = 3;
  localparam int ABORT_ACK_LSB = 4;
  localparam int TX_EMPTY_LSB = 0;
  // transmitter control layout: abort requests high, enables low
  localparam int ABORT_REQ_LSB = 4;
  localparam int TX_ENABLE_LSB = 0;

  // error counter thresholds
  localparam int COUNT_WIDTH = 9;
  localparam logic [8:0] WARN_LIMIT = 9'h060;     // 96
  localparam logic [8:0] PASSIVE_LIMIT = 9'h080;  // 128
  localparam logic [8:0] COUNT_MAX = 9'h0FF;      // 255
  // bus-off recovery: occurrences of eleven recessive bits
  localparam int RECOVERY_OCCURRENCES = 128;

  // values after reset
  localparam logic [7:0] RX_FLAGS_RESET = 8'h00;
  localparam logic [7:0] RX_ENABLES_RESET = 8'h00;
  localparam logic [2:0] TX_EMPTY_RESET = 3'h7;
  localparam logic [2:0] TX_ENABLES_RESET = 3'h0;
  localparam logic CONTROL_RESET = 1'b0;

  // software register byte offsets
  localparam logic [7:0] MODULE_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] RX_FLAGS_OFFSET = 8'h04;
  localparam logic [7:0] RX_ENABLES_OFFSET = 8'h08;
  localparam logic [7:0] TX_FLAGS_OFFSET = 8'h0C;
  localparam logic [7:0] TX_CONTROL_OFFSET = 8'h10;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h14;
  localparam int SOFT_RESET_BIT = 0;
endpackage

/* File: hw/can_flags_if.sv */
/*
  Interface joining the register-side controller to the CAN status-flag
  device end. Strobes are one-cycle pulses, the rest are levels.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/10ps
interface can_flags_if;
  // controller to device
  logic softReset;
  logic [7:0] rxFlagClear;
  logic [7:0] rxEnable;
  logic [2:0] txEmptyClear;
  logic [2:0] abortSet;
  logic [2:0] txEnable;
  // device to controller
  logic [7:0] rxFlags;
  logic [7:0] txFlags;
  logic [2:0] abortRequest;
  logic wakeIrq;
  logic errIrq;
  logic rxIrq;
  logic txIrq;

  modport dev (
    input softReset, rxFlagClear, rxEnable, txEmptyClear, abortSet,
    input txEnable,
    output rxFlags, txFlags, abortRequest, wakeIrq, errIrq, rxIrq, txIrq
  );
  modport host (
    output softReset, rxFlagClear, rxEnable, txEmptyClear, abortSet,
    output txEnable,
    input rxFlags, txFlags, abortRequest, wakeIrq, errIrq, rxIrq, txIrq
  );
endinterface

/* File: hw/busoff_recovery_counter.sv */
/*
  Counts occurrences of eleven consecutive recessive bits while bus-off.
  Assumes tick is a one-cycle pulse from the bit engine on the core clock.
*/
`timescale 1ns/10ps
module busoff_recovery_counter
  import can_flags_pkg::*;
#(
  parameter int OCCURRENCES = RECOVERY_OCCURRENCES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick,
  output logic done
);
  localparam int W = $clog2(OCCURRENCES + 1);
  localparam logic [W-1:0] LAST = W'(OCCURRENCES - 1);
  logic [W-1:0] count;

  // count ticks until the last one, then hold done until cleared
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      done <= 1'b0;
    end else if (clear) begin
      count <= '0;
      done <= 1'b0;
    end else if (tick && !done) begin
      count <= count + W'(1);
      if (count == LAST) begin
        done <= 1'b1;
      end
    end
  end
endmodule

/* File: hw/can_status_flags.sv */
/*
  Device end: receiver flags, transmitter empty flags, abort handling and
  interrupt generation of a CAN controller.
  Assumes error counts and events come from the protocol engine on the
  same core clock; events are one-cycle pulses.
*/
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps
module can_status_flags
  import can_flags_pkg::*;
#(
  parameter int BUFFERS = TX_BUFFERS
) (
  input wire logic core_clk,
  input wire logic rst,
  can_flags_if.dev bus,
  input wire logic [COUNT_WIDTH-1:0] receiveErrorCount,
  input wire logic [COUNT_WIDTH-1:0] transmitErrorCount,
  input wire logic sleepBusActivity,
  input wire logic overrunEvent,
  input wire logic rxMessageDone,
  input wire logic recessive11Seen,
  input wire logic [BUFFERS-1:0] txSent,
  input wire logic [BUFFERS-1:0] txAborted,
  output logic foregroundLoad,
  output logic protocolAbort,
  output logic [BUFFERS-1:0] abortPending,
  output logic wakeIrq,
  output logic errIrq,
  output logic rxIrq,
  output logic txIrq
);
  logic [7:0] rxFlags;
  logic [7:0] rxSet;
  logic [7:0] rxClearable;
  logic [BUFFERS-1:0] txEmpty;
  logic [BUFFERS-1:0] abortAck;
  logic [BUFFERS-1:0] txEmptySet;
  logic recoveryDone;
  // raw threshold results, before the other flags are taken into account
  logic countersWarnRx;
  logic countersWarnTx;
  logic countersPassiveRx;
  logic countersPassiveTx;
  logic countersBusOff;

  // threshold compares on the error counters
  assign countersWarnRx = receiveErrorCount >= WARN_LIMIT;
  assign countersWarnTx = transmitErrorCount >= WARN_LIMIT;
  assign countersPassiveRx = receiveErrorCount >= PASSIVE_LIMIT;
  assign countersPassiveTx = (transmitErrorCount >= PASSIVE_LIMIT) &&
                             (transmitErrorCount <= COUNT_MAX);
  assign countersBusOff = transmitErrorCount > COUNT_MAX;

  // setting conditions of each receiver flag
  always_comb begin
    rxSet = '0;
    rxSet[WAKE_BIT] = sleepBusActivity;
    rxSet[RX_WARN_BIT] = countersWarnRx && !rxFlags[RX_PASSIVE_BIT] &&
      !rxFlags[TX_PASSIVE_BIT] && !rxFlags[BUS_OFF_BIT];
    rxSet[TX_WARN_BIT] = countersWarnTx && !rxFlags[RX_PASSIVE_BIT] &&
      !rxFlags[TX_PASSIVE_BIT] && !rxFlags[BUS_OFF_BIT];
    rxSet[RX_PASSIVE_BIT] = countersPassiveRx &&
      !rxFlags[BUS_OFF_BIT];
    rxSet[TX_PASSIVE_BIT] = countersPassiveTx &&
      !rxFlags[BUS_OFF_BIT];
    rxSet[BUS_OFF_BIT] = countersBusOff;
    rxSet[OVERRUN_BIT] = overrunEvent;
    rxSet[RX_FULL_BIT] = rxMessageDone && !rxFlags[RX_FULL_BIT];
  end

  // a flag may clear only once its cause has gone
  always_comb begin
    rxClearable = 8'hFF;
    // wake, overrun and full have no lasting cause and clear at once
    rxClearable[RX_WARN_BIT] = !countersWarnRx;
    rxClearable[TX_WARN_BIT] = !countersWarnTx;
    rxClearable[RX_PASSIVE_BIT] = !countersPassiveRx;
    rxClearable[TX_PASSIVE_BIT] = !countersPassiveTx;
    rxClearable[BUS_OFF_BIT] = recoveryDone && !countersBusOff;
  end

  // bus-off recovery runs only while the bus-off flag stands
  busoff_recovery_counter #(
    .OCCURRENCES(RECOVERY_OCCURRENCES)
  ) busoff_recovery_counter_inst (
    .core_clk(core_clk),
    .rst(rst),
    .clear(bus.softReset || !rxFlags[BUS_OFF_BIT]),
    .tick(recessive11Seen),
    .done(recoveryDone)
  );

  // receiver flags: set wins over a write-one clear
  for (genvar i = 0; i < 8; i++) begin : g_rx_flag
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        rxFlags[i] <= RX_FLAGS_RESET[i];
      end else if (bus.softReset) begin
        rxFlags[i] <= RX_FLAGS_RESET[i];
      end else if (rxSet[i]) begin
        rxFlags[i] <= 1'b1;
      end else if (bus.rxFlagClear[i] && rxClearable[i]) begin
        rxFlags[i] <= 1'b0;
      end
    end
  end

  // per-buffer empty flag, abort acknowledge and abort request
  for (genvar b = 0; b < BUFFERS; b++) begin : g_tx_buffer
    // an abort only empties a buffer whose request is still pending
    assign txEmptySet[b] = txSent[b] || (txAborted[b] && abortPending[b]);

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        txEmpty[b] <= TX_EMPTY_RESET[b];
        abortAck[b] <= 1'b0;
      end else if (bus.softReset) begin
        txEmpty[b] <= TX_EMPTY_RESET[b];
        abortAck[b] <= 1'b0;
      end else if (txEmptySet[b]) begin
        txEmpty[b] <= 1'b1;
        abortAck[b] <= txAborted[b] && abortPending[b];
      end else if (bus.txEmptyClear[b]) begin
        txEmpty[b] <= 1'b0;
        abortAck[b] <= 1'b0;
      end
    end

    // software may request an abort only of a scheduled buffer
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        abortPending[b] <= 1'b0;
      end else if (bus.softReset || txEmptySet[b]) begin
        abortPending[b] <= 1'b0;
      end else if (bus.abortSet[b] && !txEmpty[b]) begin
        abortPending[b] <= 1'b1;
      end
    end
  end

  // background to foreground move, blocked while the buffer is full
  // a message arriving while full stays in the background buffer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      foregroundLoad <= 1'b0;
    end else begin
      foregroundLoad <= rxSet[RX_FULL_BIT] && !bus.softReset;
    end
  end

  // soft reset stops bus traffic; counters are kept outside
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      protocolAbort <= 1'b1;
    end else begin
      protocolAbort <= bus.softReset;
    end
  end

  // interrupt requests, levels while flag and enable are both set
  // levels, so a cause that was masked fires as soon as it is unmasked
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wakeIrq <= 1'b0;
      errIrq <= 1'b0;
      rxIrq <= 1'b0;
      txIrq <= 1'b0;
    end else begin
      wakeIrq <= rxFlags[WAKE_BIT] && bus.rxEnable[WAKE_BIT];
      rxIrq <= rxFlags[RX_FULL_BIT] && bus.rxEnable[RX_FULL_BIT];
      errIrq <= |(rxFlags & bus.rxEnable & ERROR_CLASS_MASK);
      txIrq <= |(txEmpty & bus.txEnable);
    end
  end

  // status back to the controller
  assign bus.rxFlags = rxFlags;
  assign bus.txFlags = {1'b0, abortAck, 1'b0, txEmpty};
  assign bus.abortRequest = abortPending;
  assign bus.wakeIrq = wakeIrq;
  assign bus.errIrq = errIrq;
  assign bus.rxIrq = rxIrq;
  assign bus.txIrq = txIrq;
endmodule

/* File: hw/can_status_host.sv */
/*
  Controller end: APB slave holding the software-visible registers and
  turning writes into strobes and levels toward the device end.
  Assumes an APB master on the core clock; one wait state per access.
*/
`timescale 1ns/10ps
module can_status_host
  import can_flags_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  can_flags_if.host bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic softReset;
  logic [7:0] rxEnable;
  logic [2:0] txEnable;
  logic [7:0] rxFlagClear;
  logic [2:0] txEmptyClear;
  logic [2:0] abortSet;
  logic access;
  logic writeNow;
  logic mapped;
  logic [31:0] readValue;

  // access phase, completing on the cycle pready stands high
  assign access = psel && penable;
  assign writeNow = access && pready && pwrite;

  // address decode and read mux
  always_comb begin
    mapped = 1'b1;
    readValue = '0;
    unique case (paddr)
      MODULE_CONTROL_OFFSET: readValue[SOFT_RESET_BIT] = softReset;
      RX_FLAGS_OFFSET: readValue[7:0] = bus.rxFlags;
      RX_ENABLES_OFFSET: readValue[7:0] = rxEnable;
      TX_FLAGS_OFFSET: readValue[7:0] = bus.txFlags;
      TX_CONTROL_OFFSET: begin
        readValue[ABORT_REQ_LSB +: 3] = bus.abortRequest;
        readValue[TX_ENABLE_LSB +: 3] = txEnable;
      end
      IRQ_STATUS_OFFSET:
        readValue[3:0] = {bus.txIrq, bus.rxIrq, bus.errIrq, bus.wakeIrq};
      default: mapped = 1'b0;
    endcase
  end

  // one wait state, then a registered answer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= access && !pready;
      prdata <= (access && !pready && !pwrite) ? readValue : '0;
      pslverr <= access && !pready && !mapped;
    end
  end

  // soft reset control bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      softReset <= CONTROL_RESET;
    end else if (writeNow && paddr == MODULE_CONTROL_OFFSET) begin
      softReset <= pwdata[SOFT_RESET_BIT];
    end
  end

  // enable registers, held at reset value during soft reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxEnable <= RX_ENABLES_RESET;
      txEnable <= TX_ENABLES_RESET;
    end else if (softReset) begin
      rxEnable <= RX_ENABLES_RESET;
      txEnable <= TX_ENABLES_RESET;
    end else if (writeNow && paddr == RX_ENABLES_OFFSET) begin
      rxEnable <= pwdata[7:0];
    end else if (writeNow && paddr == TX_CONTROL_OFFSET) begin
      txEnable <= pwdata[TX_ENABLE_LSB +: 3];
    end
  end

  // one-cycle clear and abort strobes; zeros written do nothing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxFlagClear <= '0;
      txEmptyClear <= '0;
      abortSet <= '0;
    end else begin
      rxFlagClear <= (writeNow && paddr == RX_FLAGS_OFFSET) ?
                     pwdata[7:0] : '0;
      txEmptyClear <= (writeNow && paddr == TX_FLAGS_OFFSET) ?
                      pwdata[TX_EMPTY_LSB +: 3] : '0;
      abortSet <= (writeNow && paddr == TX_CONTROL_OFFSET && !softReset) ?
                  pwdata[ABORT_REQ_LSB +: 3] : '0;
    end
  end

  assign bus.softReset = softReset;
  assign bus.rxEnable = rxEnable;
  assign bus.txEnable = txEnable;
  assign bus.rxFlagClear = rxFlagClear;
  assign bus.txEmptyClear = txEmptyClear;
  assign bus.abortSet = abortSet;
endmodule

/* File: verification/can_status_props.sv */
/*
  Checker for the link between the controller and device ends.
  Assumes one core clock; link signals arrive as plain inputs.
*/
`timescale 1ns/10ps
module can_status_props
  import can_flags_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic softReset,
  input wire logic [7:0] rxFlagClear,
  input wire logic [7:0] rxEnable,
  input wire logic [2:0] txEmptyClear,
  input wire logic [2:0] abortSet,
  input wire logic [2:0] txEnable,
  input wire logic [7:0] rxFlags,
  input wire logic [7:0] txFlags,
  input wire logic [2:0] abortRequest,
  input wire logic wakeIrq,
  input wire logic errIrq,
  input wire logic rxIrq,
  input wire logic txIrq
);
  logic errCause;
  logic txCause;
  // gated causes of the shared and transmit interrupts
  assign errCause = |(rxFlags & rxEnable & ERROR_CLASS_MASK);
  assign txCause = |(txFlags[2:0] & txEnable);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // soft reset holds registers at their reset values
  chk_soft_rx_hold:
    assert property (softReset && $past(softReset) |->
      rxFlags == RX_FLAGS_RESET && rxEnable == RX_ENABLES_RESET)
    else $error("rx registers moved during soft reset");
  chk_soft_tx_hold:
    assert property (softReset && $past(softReset) |->
      txFlags == {5'h00, TX_EMPTY_RESET} && abortRequest == 3'h0)
    else $error("tx registers moved during soft reset");
  // interrupts follow the gated flags one edge later
  chk_err_irq_or:
    assert property (errIrq == $past(errCause))
    else $error("error interrupt differs from gated flags");
  chk_wake_irq_gate:
    assert property (wakeIrq == ($past(rxFlags[7]) && $past(rxEnable[7])))
    else $error("wake interrupt differs from gated flag");
  chk_rx_irq_gate:
    assert property (rxIrq == ($past(rxFlags[0]) && $past(rxEnable[0])))
    else $error("receive interrupt differs from gated flag");
  chk_tx_irq_gate:
    assert property (txIrq == $past(txCause))
    else $error("transmit interrupt differs from gated flags");
  // a set flag only drops when a clear was asked for
  chk_flag_no_drop:
    assert property (!softReset |=>
      (($past(rxFlags) & ~$past(rxFlagClear)) & ~rxFlags) == 8'h00)
    else $error("receiver flag dropped without a clear");
  // abort requests cannot outlast an empty flag
  chk_abort_drop:
    assert property ((abortRequest & txFlags[2:0] & $past(txFlags[2:0]))
      == 3'h0)
    else $error("abort request stayed with buffer empty");
  chk_ack_needs_empty:
    assert property ((txFlags[6:4] & ~txFlags[2:0] & ~$past(txFlags[2:0]))
      == 3'h0)
    else $error("abort acknowledge stayed on a scheduled buffer");
  // requests only rise, and schedules only start, on a strobe from the controller
  chk_abort_refused:
    assert property (!softReset |=>
      (abortRequest & ~$past(abortRequest) & ~$past(abortSet)) == 3'h0)
    else $error("abort request rose without a request strobe");
  chk_clear_schedules:
    assert property (!softReset |=>
      (~txFlags[2:0] & $past(txFlags[2:0]) & ~$past(txEmptyClear)) == 3'h0)
    else $error("empty flag dropped without a clear strobe");
  // main scenarios
  cover property ($rose(errIrq));
  cover property ($rose(txFlags[4]));
  cover property ($rose(softReset));
  cover property (rxFlags[BUS_OFF_BIT] ##1 !rxFlags[BUS_OFF_BIT]);
endmodule

/* File: verification/can_status_interrupt_flags_bench.sv */
/*
  Bench joining the controller and device ends through the link.
  Assumes APB access to the controller registers on one core clock.
*/
`timescale 1ns/10ps
module can_status_interrupt_flags_bench
  import can_flags_pkg::*;
;
  typedef struct packed {
    logic [8:0] rxCount;
    logic [8:0] txCount;
    logic [7:0] flags;
  } row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, readData;
  logic pready, pslverr, slvErr;
  logic [COUNT_WIDTH-1:0] rxCount = 9'h000, txCount = 9'h000;
  logic [3:0] evtPulse = 4'h0; // wake, overrun, rx done, recessive run
  logic [2:0] txSent = 3'h0, txAborted = 3'h0, abortPending;
  logic foregroundLoad, protocolAbort, wakeIrq, errIrq, rxIrq, txIrq;
  int n_fail = 0, cmp_count = 0, loads = 0;
  row_t rows [9] = '{'{9'h05F, 9'h05F, 8'h00}, '{9'h060, 9'h000, 8'h40},
    '{9'h07F, 9'h000, 8'h40}, '{9'h080, 9'h000, 8'h50},
    '{9'h000, 9'h060, 8'h20}, '{9'h000, 9'h07F, 8'h20},
    '{9'h000, 9'h080, 8'h28}, '{9'h000, 9'h0FF, 8'h28},
    '{9'h060, 9'h060, 8'h60}};

  can_flags_if link ();
  can_status_flags can_status_flags_inst (.core_clk(core_clk), .rst(rst),
    .bus(link.dev), .receiveErrorCount(rxCount),
    .transmitErrorCount(txCount), .sleepBusActivity(evtPulse[0]),
    .overrunEvent(evtPulse[1]), .rxMessageDone(evtPulse[2]),
    .recessive11Seen(evtPulse[3]), .txSent(txSent), .txAborted(txAborted),
    .foregroundLoad(foregroundLoad), .protocolAbort(protocolAbort),
    .abortPending(abortPending), .wakeIrq(wakeIrq), .errIrq(errIrq),
    .rxIrq(rxIrq), .txIrq(txIrq));
  can_status_host can_status_host_inst (.core_clk(core_clk), .rst(rst),
    .bus(link.host), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  can_status_props can_status_props_inst (.core_clk(core_clk), .rst(rst),
    .softReset(link.softReset), .rxFlagClear(link.rxFlagClear),
    .rxEnable(link.rxEnable), .txEmptyClear(link.txEmptyClear),
    .abortSet(link.abortSet), .txEnable(link.txEnable),
    .rxFlags(link.rxFlags), .txFlags(link.txFlags),
    .abortRequest(link.abortRequest), .wakeIrq(link.wakeIrq),
    .errIrq(link.errIrq), .rxIrq(link.rxIrq), .txIrq(link.txIrq));

  // clock and count of foreground reloads
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (foregroundLoad === 1'b1) loads <= loads + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // one transfer after a settling gap, held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    repeat (3) @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    readData = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    check(readData, want);
  endtask
  // one-cycle pulses on the protocol engine inputs
  task automatic pulse(input logic [3:0] e, input logic [2:0] s,
    input logic [2:0] ab);
    @(posedge core_clk);
    evtPulse <= e;
    txSent <= s;
    txAborted <= ab;
    @(posedge core_clk);
    evtPulse <= 4'h0;
    txSent <= 3'h0;
    txAborted <= 3'h0;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    end_sim();
  end

  // main sequence: reset values, threshold table, then awkward cases
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(RX_FLAGS_OFFSET, 32'h0);
    rd(RX_ENABLES_OFFSET, 32'h0);
    rd(TX_FLAGS_OFFSET, 32'h07);
    rd(TX_CONTROL_OFFSET, 32'h0);
    check({31'h0, slvErr}, 32'h0);
    rd(8'h18, 32'h0);
    check({31'h0, slvErr}, 32'h1);
    wr(RX_ENABLES_OFFSET, 32'h7E);
    foreach (rows[i]) begin
      rxCount <= rows[i].rxCount;
      txCount <= rows[i].txCount;
      rd(RX_FLAGS_OFFSET, {24'h0, rows[i].flags});
      rd(IRQ_STATUS_OFFSET, {30'h0, |rows[i].flags, 1'b0});
      wr(RX_FLAGS_OFFSET, 32'hFF);
      rd(RX_FLAGS_OFFSET, {24'h0, rows[i].flags});
      rxCount <= 9'h000;
      txCount <= 9'h000;
      wr(RX_FLAGS_OFFSET, 32'hFF);
      rd(RX_FLAGS_OFFSET, 32'h0);
    end
    // receive full: second message must not reload the foreground
    wr(RX_ENABLES_OFFSET, 32'h81);
    pulse(4'h4, 3'h0, 3'h0);
    pulse(4'h4, 3'h0, 3'h0);
    rd(RX_FLAGS_OFFSET, 32'h01);
    check(32'(loads), 32'h1);
    rd(IRQ_STATUS_OFFSET, 32'h4);
    check({31'h0, rxIrq}, 32'h1);
    wr(RX_FLAGS_OFFSET, 32'h00);
    rd(RX_FLAGS_OFFSET, 32'h01);
    wr(RX_FLAGS_OFFSET, 32'h01);
    rd(RX_FLAGS_OFFSET, 32'h00);
    pulse(4'h1, 3'h0, 3'h0);
    rd(RX_FLAGS_OFFSET, 32'h80);
    rd(IRQ_STATUS_OFFSET, 32'h1);
    check({31'h0, wakeIrq}, 32'h1);
    wr(RX_FLAGS_OFFSET, 32'h80);
    // overrun raises the error interrupt until masked
    wr(RX_ENABLES_OFFSET, 32'h02);
    pulse(4'h2, 3'h0, 3'h0);
    rd(IRQ_STATUS_OFFSET, 32'h2);
    check({31'h0, errIrq}, 32'h1);
    wr(RX_ENABLES_OFFSET, 32'h00);
    rd(IRQ_STATUS_OFFSET, 32'h0);
    rd(RX_FLAGS_OFFSET, 32'h02);
    wr(RX_FLAGS_OFFSET, 32'h02);
    // bus-off clears only after the full recovery count
    txCount <= 9'h100;
    rd(RX_FLAGS_OFFSET, 32'h24);
    txCount <= 9'h000;
    wr(RX_FLAGS_OFFSET, 32'h24);
    rd(RX_FLAGS_OFFSET, 32'h04);
    repeat (127) pulse(4'h8, 3'h0, 3'h0);
    wr(RX_FLAGS_OFFSET, 32'h04);
    rd(RX_FLAGS_OFFSET, 32'h04);
    pulse(4'h8, 3'h0, 3'h0);
    wr(RX_FLAGS_OFFSET, 32'h04);
    rd(RX_FLAGS_OFFSET, 32'h00);
    // transmit buffers: schedule, abort, send
    wr(TX_CONTROL_OFFSET, 32'h07);
    rd(IRQ_STATUS_OFFSET, 32'h8);
    wr(TX_FLAGS_OFFSET, 32'h01);
    rd(TX_FLAGS_OFFSET, 32'h06);
    wr(TX_CONTROL_OFFSET, 32'h17);
    wr(TX_CONTROL_OFFSET, 32'h07);
    rd(TX_CONTROL_OFFSET, 32'h17);
    check({29'h0, abortPending}, 32'h1);
    pulse(4'h0, 3'h0, 3'h1);
    rd(TX_FLAGS_OFFSET, 32'h17);
    rd(TX_CONTROL_OFFSET, 32'h07);
    wr(TX_FLAGS_OFFSET, 32'h01);
    rd(TX_FLAGS_OFFSET, 32'h06);
    wr(TX_FLAGS_OFFSET, 32'h70);
    rd(TX_FLAGS_OFFSET, 32'h06);
    pulse(4'h0, 3'h1, 3'h0);
    rd(TX_FLAGS_OFFSET, 32'h07);
    wr(TX_CONTROL_OFFSET, 32'h27);
    rd(TX_CONTROL_OFFSET, 32'h07);
    wr(TX_FLAGS_OFFSET, 32'h07);
    rd(IRQ_STATUS_OFFSET, 32'h0);
    pulse(4'h0, 3'h6, 3'h0);
    rd(IRQ_STATUS_OFFSET, 32'h8);
    check({31'h0, txIrq}, 32'h1);
    // soft reset empties and holds every register except module control
    wr(RX_ENABLES_OFFSET, 32'hFF);
    pulse(4'h2, 3'h0, 3'h0);
    wr(MODULE_CONTROL_OFFSET, 32'h1);
    rd(RX_FLAGS_OFFSET, 32'h00);
    check({31'h0, protocolAbort}, 32'h1);
    pulse(4'h2, 3'h0, 3'h0);
    rd(RX_FLAGS_OFFSET, 32'h00);
    rd(TX_FLAGS_OFFSET, 32'h07);
    wr(RX_ENABLES_OFFSET, 32'hFF);
    rd(RX_ENABLES_OFFSET, 32'h00);
    rd(TX_CONTROL_OFFSET, 32'h00);
    wr(MODULE_CONTROL_OFFSET, 32'h0);
    rd(MODULE_CONTROL_OFFSET, 32'h0);
    check({31'h0, protocolAbort}, 32'h0);
    // hard reset in mid-run clears what events and software had set
    wr(RX_ENABLES_OFFSET, 32'h80);
    pulse(4'h1, 3'h0, 3'h0);
    wr(TX_FLAGS_OFFSET, 32'h01);
    check({31'h0, wakeIrq}, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(RX_FLAGS_OFFSET, 32'h0);
    rd(TX_FLAGS_OFFSET, 32'h07);
    rd(RX_ENABLES_OFFSET, 32'h0);
    check({31'h0, wakeIrq}, 32'h0);
    end_sim();
  end
endmodule
